// file: rtl/xad_pkg.sv
// constants and types for the xor/abs/adc decode and execute block
package xad_pkg;
	// register byte offsets
	localparam logic [4:0] OFS_CTRL   = 5'h00;
	localparam logic [4:0] OFS_SRC    = 5'h04;
	localparam logic [4:0] OFS_DST    = 5'h08;
	localparam logic [4:0] OFS_RESULT = 5'h0c;
	localparam logic [4:0] OFS_STATUS = 5'h10;
	// control word fields
	localparam int CTRL_START   = 0;
	localparam int CTRL_OP_LSB  = 1;
	localparam int CTRL_SIZE    = 3;
	localparam int CTRL_SRC_LSB = 4;
	localparam int CTRL_DST_LSB = 8;
	localparam int CTRL_SRC_IMM = 12;
	localparam int CTRL_CARRY   = 13;
	localparam int CTRL_WAIT_LSB = 16;
	localparam int OP_W   = 2;
	localparam int CODE_W = 4;
	localparam int WAIT_W = 4;
	// status word fields
	localparam int ST_BUSY    = 0;
	localparam int ST_DONE    = 1;
	localparam int ST_SIGN    = 2;
	localparam int ST_ZERO    = 3;
	localparam int ST_CARRY   = 4;
	localparam int ST_ILLEGAL = 5;
	localparam int ST_LEN_LSB = 8;
	localparam int ST_CYC_LSB = 16;
	// operand field codes
	localparam logic [3:0] CODE_ADDR_REG_ZERO = 4'h4;
	localparam logic [3:0] CODE_ADDR_REG_ONE  = 4'h5;
	localparam logic [3:0] CODE_MEM_FIRST     = 4'h6;
	localparam logic [3:0] CODE_DSP8_FIRST    = 4'h8;
	localparam logic [3:0] CODE_DSP16_FIRST   = 4'hc;
	// base lengths and cycle counts
	localparam logic [3:0] BYTES_SHORT   = 4'h2;
	localparam logic [3:0] BYTES_IMM     = 4'h3;
	localparam logic [7:0] CYC_ABS_REG   = 8'h03;
	localparam logic [7:0] CYC_ABS_MEM   = 8'h05;
	localparam logic [7:0] CYC_IMM_REG   = 8'h02;
	localparam logic [7:0] CYC_IMM_MEM   = 8'h04;
	localparam logic [7:0] CYC_PAIR_BASE = 8'h02;
	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [1:0] {
		XAD_OP_XOR     = 2'b00,
		XAD_OP_ABS     = 2'b01,
		XAD_OP_ADC_IMM = 2'b10,
		XAD_OP_ADC_REG = 2'b11
	} xad_op_type;
	typedef enum logic {
		XAD_IDLE = 1'b0,
		XAD_RUN  = 1'b1
	} xad_state_type;
	// decoded timing of one instruction
	typedef struct packed {
		logic [3:0] length;
		logic [7:0] cycles;
	} xad_timing_type;
	// whole state of the block
	typedef struct packed {
		xad_state_type state;
		logic          awready;
		logic          wready;
		logic          bvalid;
		logic [1:0]    bresp;
		logic          arready;
		logic          rvalid;
		logic [1:0]    rresp;
		logic [31:0]   rdata;
		logic          aw_got;
		logic          w_got;
		logic [4:0]    awaddr;
		logic [31:0]   wdata;
		logic [3:0]    wstrb;
		logic [31:0]   ctrl;
		logic [15:0]   src_val;
		logic [15:0]   dst_val;
		logic [15:0]   result;
		logic          busy;
		logic          done;
		logic          fin;
		logic          sign;
		logic          zero;
		logic          carry;
		logic          illegal;
		logic [3:0]    length;
		logic [7:0]    cycles;
		logic [7:0]    count;
	} xad_core_type;
	localparam xad_core_type XAD_CORE_RESET = '0;
endpackage

// file: rtl/xad_exec.sv
// decode and execute unit for xor, abs and adc behind an axi4-lite slave
// Overview of operation
// - xor combines source and destination bit by bit and writes the result to the destination.
// - byte xor into an address register zero-extends the source and works at 16 bits.
// - byte xor from an address register uses only its low 8 bits as source.
// - the sign flag follows the most significant bit of the result.
// - the zero flag is set exactly when the result is zero.
// - displacement, absolute and immediate bytes count only when the operand form needs them.
// - length in bytes and execution cycles follow the timing tables.
// - software wait states add stall cycles for each memory access.
// - word size adds one byte to adc with an immediate operand.
//
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module xad_exec (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// write address and data
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] awaddr,
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	// write response
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	// read address and data
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [31:0] araddr,
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp
);
	xad_pkg::xad_core_type r;
	xad_pkg::xad_core_type n;

	////////////////////////////////////////////////////////////////////////////
	// operand form decoding
	function automatic logic is_areg(input logic [3:0] code);
		is_areg = (code == xad_pkg::CODE_ADDR_REG_ZERO) || (code == xad_pkg::CODE_ADDR_REG_ONE);
	endfunction

	function automatic logic is_mem(input logic [3:0] code);
		is_mem = (code >= xad_pkg::CODE_MEM_FIRST);
	endfunction

	// extra bytes after the opcode for one operand form
	function automatic logic [3:0] ext_bytes(input logic [3:0] code);
		if (code == 4'hf || code >= xad_pkg::CODE_DSP16_FIRST) begin
			ext_bytes = 4'h2;
		end else if (code >= xad_pkg::CODE_DSP8_FIRST) begin
			ext_bytes = 4'h1;
		end else begin
			ext_bytes = 4'h0;
		end
	endfunction

	// length and total cycles for a control word
	function automatic xad_pkg::xad_timing_type decode(input logic [31:0] c);
		xad_pkg::xad_op_type op;
		logic [3:0] sc;
		logic [3:0] dc;
		logic       sz;
		logic       imm;
		logic       smem;
		logic       dmem;
		logic [7:0] wt;
		op   = xad_pkg::xad_op_type'(c[xad_pkg::CTRL_OP_LSB +: xad_pkg::OP_W]);
		sc   = c[xad_pkg::CTRL_SRC_LSB +: xad_pkg::CODE_W];
		dc   = c[xad_pkg::CTRL_DST_LSB +: xad_pkg::CODE_W];
		sz   = c[xad_pkg::CTRL_SIZE];
		wt   = {4'h0, c[xad_pkg::CTRL_WAIT_LSB +: xad_pkg::WAIT_W]};
		imm  = (op == xad_pkg::XAD_OP_ADC_IMM) || (op == xad_pkg::XAD_OP_XOR && c[xad_pkg::CTRL_SRC_IMM]);
		smem = is_mem(sc) && !imm && (op != xad_pkg::XAD_OP_ABS);
		dmem = is_mem(dc);
		if (op == xad_pkg::XAD_OP_ABS) begin
			decode.length = xad_pkg::BYTES_SHORT + ext_bytes(dc);
			decode.cycles = dmem ? xad_pkg::CYC_ABS_MEM : xad_pkg::CYC_ABS_REG;
		end else if (imm) begin
			decode.length = xad_pkg::BYTES_IMM + ext_bytes(dc) + {3'h0, sz};
			decode.cycles = dmem ? xad_pkg::CYC_IMM_MEM : xad_pkg::CYC_IMM_REG;
		end else begin
			decode.length = xad_pkg::BYTES_SHORT + ext_bytes(sc) + ext_bytes(dc);
			decode.cycles = xad_pkg::CYC_PAIR_BASE + {7'h0, smem} + {7'h0, dmem};
		end
		decode.cycles = decode.cycles + (smem ? wt : 8'h00) + (dmem ? wt : 8'h00);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// datapath on the latched operands
	xad_pkg::xad_op_type op;
	logic        size;
	logic        wide;
	logic [15:0] srcv;
	logic [15:0] dstv;
	logic [16:0] sum;
	logic [15:0] alu;
	logic [15:0] res;
	logic        res_sign;
	logic        res_zero;
	logic        res_carry;

	always_comb begin
		op   = xad_pkg::xad_op_type'(r.ctrl[xad_pkg::CTRL_OP_LSB +: xad_pkg::OP_W]);
		size = r.ctrl[xad_pkg::CTRL_SIZE];
		// a byte op into an address register runs at full width
		wide = size || is_areg(r.ctrl[xad_pkg::CTRL_DST_LSB +: xad_pkg::CODE_W]);
		// byte source keeps only its low byte, zero-extended
		srcv = size ? r.src_val : {8'h00, r.src_val[7:0]};
		dstv = wide ? r.dst_val : {8'h00, r.dst_val[7:0]};
		sum  = {1'b0, dstv} + {1'b0, srcv} + {16'h0000, r.ctrl[xad_pkg::CTRL_CARRY]};
		res_carry = r.carry;
		unique case (op)
			xad_pkg::XAD_OP_XOR: begin
				alu = dstv ^ srcv;
			end
			xad_pkg::XAD_OP_ABS: begin
				alu = (wide ? dstv[15] : dstv[7]) ? 16'h0000 - dstv : dstv;
			end
			xad_pkg::XAD_OP_ADC_IMM, xad_pkg::XAD_OP_ADC_REG: begin
				alu = sum[15:0];
				res_carry = wide ? sum[16] : sum[8];
			end
		endcase
		// byte results leave the destination high byte alone
		res      = wide ? alu : {r.dst_val[15:8], alu[7:0]};
		res_sign = wide ? alu[15] : alu[7];
		res_zero = wide ? (alu == 16'h0000) : (alu[7:0] == 8'h00);
	end

	////////////////////////////////////////////////////////////////////////////
	// bus slave and sequencer
	logic [31:0]                 ctrl_new;
	logic [31:0]                 status;
	logic                        go;
	xad_pkg::xad_timing_type     tim;

	always_comb begin
		n     = r;
		n.fin = 1'b0;
		go    = 1'b0;
		ctrl_new = r.ctrl;
		for (int i = 0; i < 4; i++) begin
			if (r.wstrb[i]) begin
				ctrl_new[8*i +: 8] = r.wdata[8*i +: 8];
			end
		end
		tim = decode(ctrl_new);
		status = 32'h0000_0000;
		status[xad_pkg::ST_BUSY]    = r.busy;
		status[xad_pkg::ST_DONE]    = r.done;
		status[xad_pkg::ST_SIGN]    = r.sign;
		status[xad_pkg::ST_ZERO]    = r.zero;
		status[xad_pkg::ST_CARRY]   = r.carry;
		status[xad_pkg::ST_ILLEGAL] = r.illegal;
		status[xad_pkg::ST_LEN_LSB +: 4] = r.length;
		status[xad_pkg::ST_CYC_LSB +: 8] = r.cycles;
		// write channel: address and data taken in either order
		if (awvalid && r.awready) begin
			n.aw_got = 1'b1;
			n.awaddr = awaddr[4:0];
		end
		if (wvalid && r.wready) begin
			n.w_got = 1'b1;
			n.wdata = wdata;
			n.wstrb = wstrb;
		end
		if (r.bvalid && bready) begin
			n.bvalid = 1'b0;
		end
		if (r.aw_got && r.w_got && !r.bvalid) begin
			n.aw_got = 1'b0;
			n.w_got  = 1'b0;
			n.bvalid = 1'b1;
			n.bresp  = xad_pkg::RESP_OKAY;
			// operands stay frozen while an instruction runs
			unique case (r.awaddr)
				xad_pkg::OFS_CTRL: begin
					if (!r.busy) begin
						n.ctrl = ctrl_new & ~(32'h1 << xad_pkg::CTRL_START);
						go = r.wstrb[0] && r.wdata[xad_pkg::CTRL_START];
					end
				end
				xad_pkg::OFS_SRC: begin
					if (!r.busy && r.wstrb[0]) n.src_val[7:0] = r.wdata[7:0];
					if (!r.busy && r.wstrb[1]) n.src_val[15:8] = r.wdata[15:8];
				end
				xad_pkg::OFS_DST: begin
					if (!r.busy && r.wstrb[0]) n.dst_val[7:0] = r.wdata[7:0];
					if (!r.busy && r.wstrb[1]) n.dst_val[15:8] = r.wdata[15:8];
				end
				xad_pkg::OFS_RESULT, xad_pkg::OFS_STATUS: begin
					n.bresp = xad_pkg::RESP_OKAY;
				end
				default: begin
					n.bresp = xad_pkg::RESP_SLVERR;
				end
			endcase
		end
		n.awready = !n.aw_got && !n.bvalid;
		n.wready  = !n.w_got && !n.bvalid;
		// read channel
		if (r.rvalid && rready) begin
			n.rvalid = 1'b0;
		end
		if (arvalid && r.arready) begin
			n.rvalid = 1'b1;
			n.rresp  = xad_pkg::RESP_OKAY;
			unique case (araddr[4:0])
				xad_pkg::OFS_CTRL:   n.rdata = r.ctrl;
				xad_pkg::OFS_SRC:    n.rdata = {16'h0000, r.src_val};
				xad_pkg::OFS_DST:    n.rdata = {16'h0000, r.dst_val};
				xad_pkg::OFS_RESULT: n.rdata = {16'h0000, r.result};
				xad_pkg::OFS_STATUS: n.rdata = status;
				default: begin
					n.rdata = 32'h0000_0000;
					n.rresp = xad_pkg::RESP_SLVERR;
				end
			endcase
		end
		n.arready = !n.rvalid;
		// sequencer: count the tabulated cycles plus wait states
		unique case (r.state)
			xad_pkg::XAD_IDLE: begin
				if (go) begin
					n.state  = xad_pkg::XAD_RUN;
					n.busy   = 1'b1;
					n.done   = 1'b0;
					n.length = tim.length;
					n.cycles = tim.cycles;
					n.count  = tim.cycles;
				end
			end
			xad_pkg::XAD_RUN: begin
				if (r.count <= 8'h01) begin
					n.state   = xad_pkg::XAD_IDLE;
					n.busy    = 1'b0;
					n.done    = 1'b1;
					n.fin     = 1'b1;
					n.dst_val = res;
					n.result  = res;
					n.sign    = res_sign;
					n.zero    = res_zero;
					n.carry   = res_carry;
					// flag the forbidden pairing but still execute it
					n.illegal = (op == xad_pkg::XAD_OP_XOR) && !size && !r.ctrl[xad_pkg::CTRL_SRC_IMM]
						&& is_areg(r.ctrl[xad_pkg::CTRL_SRC_LSB +: xad_pkg::CODE_W])
						&& is_areg(r.ctrl[xad_pkg::CTRL_DST_LSB +: xad_pkg::CODE_W]);
				end else begin
					n.count = r.count - 8'h01;
				end
			end
		endcase
	end

	// one register for the whole state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r <= xad_pkg::XAD_CORE_RESET;
		end else begin
			r <= n;
		end
	end

	assign awready = r.awready;
	assign wready  = r.wready;
	assign bvalid  = r.bvalid;
	assign bresp   = r.bresp;
	assign arready = r.arready;
	assign rvalid  = r.rvalid;
	assign rdata   = r.rdata;
	assign rresp   = r.rresp;

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [15:0] p_src;
	logic [15:0] p_dst;
	logic        x_op;
	assign x_op = (op == xad_pkg::XAD_OP_XOR) && !r.ctrl[xad_pkg::CTRL_SRC_IMM];
	always_ff @(posedge aclk) begin
		p_src <= r.src_val;
		p_dst <= r.dst_val;
	end

	property p_xor_word;
		r.fin && x_op && size |-> r.result == (p_dst ^ p_src);
	endproperty
	a_xor_word: assert property (p_xor_word) else $error("word xor result wrong");
	property p_zext;
		r.fin && x_op && !size && is_areg(r.ctrl[xad_pkg::CTRL_DST_LSB +: xad_pkg::CODE_W])
			|-> r.result == (p_dst ^ {8'h00, p_src[7:0]});
	endproperty
	a_zext: assert property (p_zext) else $error("zero-extended xor wrong");
	property p_low_byte;
		r.fin && x_op && !wide |-> r.result == {p_dst[15:8], p_dst[7:0] ^ p_src[7:0]};
	endproperty
	a_low_byte: assert property (p_low_byte) else $error("byte xor wrong");
	property p_sign;
		r.fin |-> r.sign == (wide ? r.result[15] : r.result[7]);
	endproperty
	a_sign: assert property (p_sign) else $error("sign flag wrong");
	property p_zero;
		r.fin |-> r.zero == (wide ? r.result == 16'h0000 : r.result[7:0] == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");
	property p_abs_reg;
		$rose(r.busy) && op == xad_pkg::XAD_OP_ABS && r.ctrl[11:8] == 4'h0 |-> r.busy[*3] ##1 !r.busy;
	endproperty
	a_abs_reg: assert property (p_abs_reg) else $error("abs register timing wrong");
	property p_abs_mem;
		$rose(r.busy) && op == xad_pkg::XAD_OP_ABS && r.ctrl[11:8] == 4'hf && r.ctrl[19:16] == 4'h0
			|-> r.busy[*5] ##1 !r.busy;
	endproperty
	a_abs_mem: assert property (p_abs_mem) else $error("abs memory timing wrong");
	property p_wait;
		$rose(r.busy) && op == xad_pkg::XAD_OP_ABS && r.ctrl[11:8] == 4'h6 && r.ctrl[19:16] == 4'h2
			|-> r.busy[*7] ##1 !r.busy;
	endproperty
	a_wait: assert property (p_wait) else $error("wait states not added");
	property p_imm_len;
		$rose(r.busy) && op == xad_pkg::XAD_OP_ADC_IMM && r.ctrl[11:8] == 4'hf
			|-> r.length == (size ? 4'h6 : 4'h5);
	endproperty
	a_imm_len: assert property (p_imm_len) else $error("immediate length wrong");
	property p_pair_len;
		$rose(r.busy) && op == xad_pkg::XAD_OP_ADC_REG && r.ctrl[7:4] == 4'h8 && r.ctrl[11:8] == 4'hc
			|-> r.length == 4'h5 && r.cycles == 8'h04 + {r.ctrl[19:16], 1'b0};
	endproperty
	a_pair_len: assert property (p_pair_len) else $error("pair length wrong");
	c_xor: cover property (r.fin && x_op);
	c_abs_mem: cover property ($rose(r.busy) && op == xad_pkg::XAD_OP_ABS && r.cycles > 8'h05);
	c_adc_word: cover property (r.fin && op == xad_pkg::XAD_OP_ADC_IMM && size);
	c_illegal: cover property (r.fin && r.illegal);
endmodule
`default_nettype wire

// file: verif/xad_exec_bench.sv
// self-checking bench for the xor/abs/adc decode and execute block
`timescale 1ns/1ns
`default_nettype none
module xad_exec_bench;
	// clock and reset
	logic        aclk;
	logic        aresetn;
	// axi4-lite master side
	logic        awvalid;
	logic        awready;
	logic [31:0] awaddr;
	logic        wvalid;
	logic        wready;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        bvalid;
	logic        bready;
	logic [1:0]  bresp;
	logic        arvalid;
	logic        arready;
	logic [31:0] araddr;
	logic        rvalid;
	logic        rready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	// bookkeeping
	int          n_errors;
	int          cmp_count;
	logic [31:0] st;
	logic [31:0] st0;
	logic [31:0] res;
	logic [31:0] rd;
	logic [1:0]  rsp;

	xad_exec dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp));

	// free-running 20 mhz clock
	always #25 aclk = ~aclk;

	////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict;
		$display("errors %0d comparisons %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	// write: address and data offered together, bready held until bvalid is seen
	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr  <= a;
		wvalid  <= 1'b1;
		wdata   <= d;
		bready  <= 1'b1;
		r = 2'b11;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
		cmp("write answered", 32'h1, 32'(n < 50));
	endtask

	task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr  <= a;
		rready  <= 1'b1;
		d = 32'hx;
		r = 2'b11;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
		cmp("read answered", 32'h1, 32'(n < 50));
	endtask

	// control word: wait, imm, dest code, src code, size, op, start; carry left clear
	function automatic logic [31:0] ctl(input logic [1:0] op, input logic sz,
		input logic [3:0] sc, input logic [3:0] dc, input logic imm, input logic [3:0] wt);
		ctl = {12'h0, wt, 3'h0, imm, dc, sc, sz, op, 1'b1};
	endfunction

	// loads operands, starts, polls for done; the first status read is kept in st0
	task automatic run_op(input logic [31:0] c, input logic [15:0] s, input logic [15:0] d);
		int n;
		axi_wr(32'h04, {16'h0, s}, rsp);
		axi_wr(32'h08, {16'h0, d}, rsp);
		axi_wr(32'h00, c, rsp);
		st = 32'h0;
		for (n = 0; n < 40 && st[1] !== 1'b1; n++) begin
			axi_rd(32'h10, st, rsp);
			if (n == 0) st0 = st;
		end
		axi_rd(32'h0c, res, rsp);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// reset values, a plain register, unmapped addresses
	task automatic t_regs;
		axi_rd(32'h10, rd, rsp);
		cmp("status reset", 32'h0, rd);
		axi_rd(32'h14, rd, rsp);
		cmp("unmapped read resp", 32'(xad_pkg::RESP_SLVERR), 32'(rsp));
		cmp("unmapped read data", 32'h0, rd);
		axi_wr(32'h1c, 32'h5, rsp);
		cmp("unmapped write resp", 32'(xad_pkg::RESP_SLVERR), 32'(rsp));
		axi_wr(32'h04, 32'h1234, rsp);
		cmp("mapped write resp", 32'(xad_pkg::RESP_OKAY), 32'(rsp));
		axi_rd(32'h04, rd, rsp);
		cmp("src readback", 32'h1234, rd);
	endtask

	task automatic t_xor;
		run_op(ctl(2'd0, 1'b1, 4'h0, 4'h1, 1'b0, 4'h0), 16'h8001, 16'h00ff);
		cmp("xor word result", 32'h80fe, res);
		axi_rd(32'h08, rd, rsp);
		cmp("xor dest written", 32'h80fe, rd);
		cmp("xor sign set", 32'h1, 32'(st[2]));
		cmp("xor zero clear", 32'h0, 32'(st[3]));
		cmp("xor length", 32'h2, 32'(st[11:8]));
		cmp("xor cycles", 32'h2, 32'(st[23:16]));
		run_op(ctl(2'd0, 1'b1, 4'h0, 4'h1, 1'b0, 4'h0), 16'h5a5a, 16'h5a5a);
		cmp("xor zero set", 32'h1, 32'(st[3]));
		cmp("xor sign clear", 32'h0, 32'(st[2]));
		// byte into address reg zero: source high byte must vanish
		run_op(ctl(2'd0, 1'b0, 4'h0, xad_pkg::CODE_ADDR_REG_ZERO, 1'b0, 4'h0), 16'hff35, 16'h1235);
		cmp("xor zero-extend", 32'h1200, res);
		// byte from address reg one: only its low byte is used
		run_op(ctl(2'd0, 1'b0, xad_pkg::CODE_ADDR_REG_ONE, 4'h0, 1'b0, 4'h0), 16'hab12, 16'h34f0);
		cmp("xor low byte src", 32'h34e2, res);
		cmp("xor byte sign", 32'h1, 32'(st[2]));
		cmp("xor legal pairing", 32'h0, 32'(st[5]));
		// both operands address registers at byte size: flagged, still executed
		run_op(ctl(2'd0, 1'b0, xad_pkg::CODE_ADDR_REG_ZERO, xad_pkg::CODE_ADDR_REG_ONE,
			1'b0, 4'h0), 16'hab12, 16'h34f0);
		cmp("xor forbidden pairing flagged", 32'h1, 32'(st[5]));
		cmp("xor forbidden pairing result", 32'h34e2, res);
		// immediate into a dsp8 destination carries one extra byte
		run_op(ctl(2'd0, 1'b0, 4'h0, 4'h8, 1'b1, 4'h0), 16'h000f, 16'h00f0);
		cmp("xor imm result", 32'h00ff, res);
		cmp("xor imm length", 32'h4, 32'(st[11:8]));
		cmp("xor imm cycles", 32'h4, 32'(st[23:16]));
	endtask

	// abs over register and memory destination forms
	task automatic t_abs;
		logic [3:0] code [6] = '{4'h0, 4'h4, 4'h6, 4'h8, 4'hc, 4'hf};
		logic [3:0] len  [6] = '{4'h2, 4'h2, 4'h2, 4'h3, 4'h4, 4'h4};
		logic [7:0] cyc  [6] = '{8'h3, 8'h3, 8'h5, 8'h5, 8'h5, 8'h5};
		for (int i = 0; i < 6; i++) begin
			run_op(ctl(2'd1, 1'b1, 4'h0, code[i], 1'b0, 4'h0), 16'h0000, 16'hfffb);
			cmp("abs result", 32'h5, res);
			cmp("abs length", 32'(len[i]), 32'(st[11:8]));
			cmp("abs cycles", 32'(cyc[i]), 32'(st[23:16]));
		end
		// positive word in memory, two wait states per access
		run_op(ctl(2'd1, 1'b1, 4'h0, 4'h6, 1'b0, 4'h2), 16'h0000, 16'h0007);
		cmp("abs positive result", 32'h7, res);
		cmp("abs waited cycles", 32'h7, 32'(st[23:16]));
	endtask

	// adc lengths by size, pair forms, wait-state stalls
	task automatic t_adc;
		run_op(ctl(2'd2, 1'b0, 4'h0, 4'h0, 1'b0, 4'h0), 16'h0023, 16'h0100);
		cmp("adc imm byte length", 32'h3, 32'(st[11:8]));
		run_op(ctl(2'd2, 1'b1, 4'h0, 4'h0, 1'b0, 4'h0), 16'h0023, 16'h0100);
		cmp("adc imm word result", 32'h0123, res);
		cmp("adc imm word length", 32'h4, 32'(st[11:8]));
		cmp("adc imm word cycles", 32'h2, 32'(st[23:16]));
		run_op(ctl(2'd2, 1'b1, 4'h0, 4'hd, 1'b0, 4'h0), 16'h0001, 16'h0001);
		cmp("adc imm dsp16 length", 32'h6, 32'(st[11:8]));
		run_op(ctl(2'd3, 1'b1, 4'h6, 4'h8, 1'b0, 4'h0), 16'h0001, 16'h0001);
		cmp("adc pair length", 32'h3, 32'(st[11:8]));
		cmp("adc pair cycles", 32'h4, 32'(st[23:16]));
		run_op(ctl(2'd3, 1'b1, 4'hc, 4'hf, 1'b0, 4'h0), 16'h0001, 16'h0001);
		cmp("adc pair long length", 32'h6, 32'(st[11:8]));
		run_op(ctl(2'd2, 1'b1, 4'h0, 4'hf, 1'b0, 4'h0), 16'h0001, 16'h0001);
		cmp("adc imm abs16 length", 32'h6, 32'(st[11:8]));
		cmp("adc imm abs16 cycles", 32'h4, 32'(st[23:16]));
		run_op(ctl(2'd3, 1'b1, 4'h8, 4'hc, 1'b0, 4'h1), 16'h0001, 16'h0001);
		cmp("adc pair dsp length", 32'h5, 32'(st[11:8]));
		cmp("adc pair dsp cycles", 32'h6, 32'(st[23:16]));
		// byte add with carry in that carries out of the low byte
		run_op(ctl(2'd3, 1'b0, 4'h0, 4'h1, 1'b0, 4'h0) | (32'h1 << xad_pkg::CTRL_CARRY),
			16'h00ff, 16'h1201);
		cmp("adc carry result", 32'h1201, res);
		cmp("adc carry out", 32'h1, 32'(st[4]));
		run_op(ctl(2'd3, 1'b1, 4'h6, 4'h8, 1'b0, 4'h3), 16'h0001, 16'h0001);
		cmp("adc waited cycles", 32'ha, 32'(st[23:16]));
		cmp("busy while stalled", 32'h1, 32'(st0[0]));
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// watchdog: the whole run needs a few thousand cycles at most
	initial begin
		#(50 * 20000);
		n_errors++;
		give_verdict();
	end

	// main sequence
	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		awaddr = 32'h0;
		araddr = 32'h0;
		wdata = 32'h0;
		wstrb = 4'hf;
		n_errors = 0;
		cmp_count = 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_xor();
		t_abs();
		t_adc();
		give_verdict();
	end
endmodule
`default_nettype wire
